// ==== verilog/bac_ctrl.sv ====
`timescale 1ns/1ns
`include "bac_defines.svh"

// Notes on behaviour
// - no coil is driven while converter supply is absent, except the open coil from the direct open input.
// - switch only with stored energy: open needs close plus open, closed needs open.
// - close coil starts only with the breaker at its open limit.
// - an open command active together with close suppresses closing.
// - each coil drops as soon as its limit position is sensed.
// - closed limit not seen within 70 ms of a close starts an open.
// - held close plus later open gives one close-open cycle, no reclosing.
// - after that cycle close must be withdrawn and reapplied.
// - closing needs the lock-out input energised; losing it inhibits the close coil.
// - energy store recharge is watched and flagged if over 3 s.
// - full variant opens the breaker when the undervoltage input is lost.
// - the undervoltage dip must outlast a configurable tolerance time.
// - with undervoltage function enabled and no voltage, closing is refused.
// - a setting disables the undervoltage function entirely.
// - full variant flags open coil circuits, darkens lamp, sets fault contacts.
// - full variant gives closed and open position contacts.
// - full variant: direct open input drives the open coil bypassing the gating logic.
// - lamp needs supply, defined position, watchdog, energy, and coil continuity.
// - lamp ignores lock-out and undervoltage inputs.
// - lamp flashes while recharging, and switching stays enabled.
// - carriage blocking magnet is powered, releasing carriage, only with supply.
// - not-ready contact asserts when stored energy is insufficient.
// - two sensors give limit positions; both at once flags a position fault.
module bac_ctrl
  import bac_pkg::*;
#(
  parameter int unsigned CLOSE_TMO_CYC = `BAC_CLOSE_TMO_CYC,
  parameter int unsigned RECHARGE_CYC = `BAC_RECHARGE_CYC,
  parameter int unsigned FLASH_CYC = `BAC_FLASH_CYC,
  parameter int unsigned UV_UNIT_CYC = `BAC_UV_UNIT_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire bac_pkg::bac_pins_t pins,
  input wire bac_pkg::bac_cfg_t cfg,
  input wire logic watchdog_ok,
  output bac_pkg::bac_outs_t outs,
  output bac_pkg::bac_state_t state
);
  import bac_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  bac_pins_t s;

  bac_sync #(
    .W($bits(bac_pins_t))
  ) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .d(pins),
    .q(s)
  );

  ////////////////////////////////////////////////////////////////////////
  // decoded conditions

  // energy needed depends on which way the next operation goes
  function automatic logic energy_enough(input bac_pins_t p);
    energy_enough = p.pos_closed_sensor ? p.energy_open_ok : p.energy_close_open_ok;
  endfunction : energy_enough

  function automatic logic coils_intact(input bac_pins_t p, input bac_cfg_t c);
    coils_intact = !c.full_variant || (p.close_coil_intact && p.open_coil_intact);
  endfunction : coils_intact

  logic close_req, open_req, uv_func_on, uv_low, energy_ok, close_go, open_go;
  logic uv_trip_q, uv_trip_d, recharging_q;

  assign close_req = s.remote_close_input | s.local_close_button;
  assign open_req = s.remote_open_input | s.local_open_button;
  assign uv_func_on = cfg.full_variant & cfg.uv_enable;
  assign uv_low = uv_func_on & ~s.undervoltage_release_input;
  assign energy_ok = energy_enough(s);

  ////////////////////////////////////////////////////////////////////////
  // operation sequencer

  bac_state_t st_q, st_d;
  logic [31:0] tmr_q, tmr_d;
  logic used_q, used_d;

  assign close_go = s.supply_present & close_req & ~used_q & ~open_req & ~uv_trip_q
                  & s.closing_lockout_input & ~uv_low & s.pos_open_sensor
                  & ~s.pos_closed_sensor & s.energy_close_open_ok;
  assign open_go = s.supply_present & (open_req | uv_trip_q) & ~s.pos_open_sensor
                 & s.energy_open_ok;

  always_comb
  begin
    st_d = st_q;
    tmr_d = tmr_q;
    used_d = used_q;
    if (!close_req)
    begin
      used_d = 1'b0;
    end
    case (st_q)
      BAC_ST_IDLE:
      begin
        tmr_d = `BAC_RST_TMR;
        if (open_go)
        begin
          st_d = BAC_ST_OPENING;
        end
        else if (close_go)
        begin
          st_d = BAC_ST_CLOSING;
          used_d = 1'b1;
        end
      end
      BAC_ST_CLOSING:
      begin
        tmr_d = tmr_q + 32'h0000_0001;
        // supply loss or closed limit ends it
        if (!s.supply_present || s.pos_closed_sensor)
        begin
          st_d = BAC_ST_IDLE;
          tmr_d = `BAC_RST_TMR;
        end
        // timeout, open or lock-out loss aborts
        else if (((open_req || uv_trip_q) && s.energy_open_ok) || !s.closing_lockout_input
                 || (tmr_q >= CLOSE_TMO_CYC - 1))
        begin
          st_d = BAC_ST_OPENING;
          tmr_d = `BAC_RST_TMR;
        end
      end
      BAC_ST_OPENING:
      begin
        tmr_d = `BAC_RST_TMR;
        if (!s.supply_present || s.pos_open_sensor)
        begin
          st_d = BAC_ST_IDLE;
        end
      end
      default:
      begin
        st_d = BAC_ST_IDLE;
        tmr_d = `BAC_RST_TMR;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= BAC_ST_IDLE;
      tmr_q <= `BAC_RST_TMR;
      used_q <= `BAC_RST_BIT;
    end
    else if (ce)
    begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      used_q <= used_d;
    end
  end

  assign state = st_q;

  ////////////////////////////////////////////////////////////////////////
  // undervoltage tolerance

  logic [31:0] uv_cnt_q, uv_cnt_d, uv_tol;

  assign uv_tol = 32'(cfg.uv_tol_units) * UV_UNIT_CYC;

  // trip only once the dip outlasts the setting
  always_comb
  begin
    uv_cnt_d = `BAC_RST_TMR;
    uv_trip_d = 1'b0;
    if (uv_low)
    begin
      uv_trip_d = uv_trip_q | (uv_cnt_q >= uv_tol);
      uv_cnt_d = uv_trip_d ? uv_cnt_q : uv_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      uv_cnt_q <= `BAC_RST_TMR;
      uv_trip_q <= `BAC_RST_BIT;
    end
    else if (ce)
    begin
      uv_cnt_q <= uv_cnt_d;
      uv_trip_q <= uv_trip_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // recharge watch and lamp flash

  logic recharging_d, rch_fault_q, rch_fault_d, flash_q, flash_d, op_start;
  logic [31:0] rch_cnt_q, rch_cnt_d, fl_cnt_q, fl_cnt_d;

  assign op_start = (st_q == BAC_ST_IDLE) && (st_d != BAC_ST_IDLE);

  // overdue recharge is flagged; a new operation restarts the watch
  always_comb
  begin
    recharging_d = recharging_q;
    rch_cnt_d = rch_cnt_q;
    rch_fault_d = rch_fault_q;
    if (op_start)
    begin
      recharging_d = 1'b1;
      rch_cnt_d = `BAC_RST_TMR;
    end
    else if (recharging_q && s.store_full && st_q == BAC_ST_IDLE)
    begin
      recharging_d = 1'b0;
      rch_fault_d = 1'b0;
    end
    else if (recharging_q)
    begin
      if (rch_cnt_q >= RECHARGE_CYC - 1)
      begin
        rch_fault_d = 1'b1;
      end
      else
      begin
        rch_cnt_d = rch_cnt_q + 32'h0000_0001;
      end
    end
    fl_cnt_d = fl_cnt_q + 32'h0000_0001;
    flash_d = flash_q;
    if (fl_cnt_q >= FLASH_CYC - 1)
    begin
      fl_cnt_d = `BAC_RST_TMR;
      flash_d = ~flash_q;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      recharging_q <= `BAC_RST_BIT;
      rch_cnt_q <= `BAC_RST_TMR;
      rch_fault_q <= `BAC_RST_BIT;
      fl_cnt_q <= `BAC_RST_TMR;
      flash_q <= `BAC_RST_BIT;
    end
    else if (ce)
    begin
      recharging_q <= recharging_d;
      rch_cnt_q <= rch_cnt_d;
      rch_fault_q <= rch_fault_d;
      fl_cnt_q <= fl_cnt_d;
      flash_q <= flash_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output register

  bac_outs_t out_q, out_d;
  logic ready;

  // lamp terms, lock-out and undervoltage left out on purpose
  // during recharge the energy term is waived so readiness stays shown
  assign ready = s.supply_present & (s.pos_open_sensor ^ s.pos_closed_sensor) & watchdog_ok
               & (energy_ok | recharging_q) & coils_intact(s, cfg);

  always_comb
  begin
    out_d = '0;
    out_d.close_coil = (st_d == BAC_ST_CLOSING) & s.supply_present;
    // direct open skips the sequencer; the coil still drops at the limit
    out_d.open_coil = ((st_d == BAC_ST_OPENING) & s.supply_present)
                    | (cfg.full_variant & s.direct_open_input & ~s.pos_open_sensor);
    out_d.ready_lamp = ready & (~recharging_q | flash_q);
    out_d.not_ready_contact = ~energy_ok;
    out_d.close_coil_fault_contact = cfg.full_variant & ~s.close_coil_intact;
    out_d.open_coil_fault_contact = cfg.full_variant & ~s.open_coil_intact;
    out_d.closed_position_contact = cfg.full_variant & s.pos_closed_sensor;
    out_d.open_position_contact = cfg.full_variant & s.pos_open_sensor;
    out_d.carriage_blocking_magnet = s.supply_present;
    out_d.charger_enable = s.supply_present & ~s.store_full;
    out_d.recharge_fault = rch_fault_q;
    // both sensors at once is impossible mechanically
    out_d.position_fault = s.pos_open_sensor & s.pos_closed_sensor;
    out_d.uv_trip = uv_trip_q;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_q <= '0;
    end
    else if (ce)
    begin
      out_q <= out_d;
    end
  end

  assign outs = out_q;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n || !ce);

  close_needs_supply_a: assert property (out_q.close_coil |-> $past(s.supply_present))
    else $error("close coil driven without supply");
  close_from_open_a: assert property ($rose(st_q == BAC_ST_CLOSING) |-> $past(s.pos_open_sensor)
                                      && $past(energy_ok))
    else $error("close started away from open limit or without energy");
  close_vs_open_a: assert property ((st_q == BAC_ST_IDLE && open_req) |=> st_q != BAC_ST_CLOSING)
    else $error("close started with open active");
  coil_drop_limit_a: assert property ((st_q == BAC_ST_CLOSING && s.pos_closed_sensor)
                                      |=> !out_q.close_coil)
    else $error("close coil held at closed limit");
  close_timeout_a: assert property ((st_q == BAC_ST_CLOSING && tmr_q == CLOSE_TMO_CYC - 1
                                     && s.supply_present && !s.pos_closed_sensor)
                                    |=> st_q == BAC_ST_OPENING)
    else $error("close timeout did not start an open");
  no_repump_a: assert property ((st_q == BAC_ST_CLOSING) ##1 (st_q != BAC_ST_CLOSING)
                                ##1 close_req[*2] |-> st_q != BAC_ST_CLOSING)
    else $error("reclosed without command withdrawal");
  lockout_gate_a: assert property ($rose(st_q == BAC_ST_CLOSING) |-> $past(s.closing_lockout_input))
    else $error("closed without lock-out energised");
  uv_refuse_a: assert property ($rose(st_q == BAC_ST_CLOSING) |-> !$past(uv_low))
    else $error("closed while undervoltage input is dead");
  lamp_dark_fault_a: assert property ((cfg.full_variant && !s.close_coil_intact) |=> !out_q.ready_lamp)
    else $error("lamp lit with broken close coil");
  not_ready_a: assert property (!energy_ok |=> out_q.not_ready_contact)
    else $error("not-ready contact missing");

  cover_close_c: cover property ($rose(st_q == BAC_ST_CLOSING) ##[1:1000] st_q == BAC_ST_IDLE);
  cover_pump_c: cover property ((st_q == BAC_ST_CLOSING) ##1 (st_q == BAC_ST_OPENING));
  cover_uv_c: cover property ($rose(uv_trip_q));

endmodule : bac_ctrl

// ==== verilog/bac_defines.svh ====
`ifndef BAC_DEFINES_SVH
`define BAC_DEFINES_SVH

// clock rate
`define BAC_CLK_HZ 100000000
`define BAC_CYC_PER_MS (`BAC_CLK_HZ / 1000)

// close must reach the closed limit within this time
`define BAC_CLOSE_TMO_MS 70
`define BAC_CLOSE_TMO_CYC (`BAC_CLOSE_TMO_MS * `BAC_CYC_PER_MS)

// longest recharge of the energy store after an operation
`define BAC_RECHARGE_MS 3000
`define BAC_RECHARGE_CYC (`BAC_RECHARGE_MS * `BAC_CYC_PER_MS)

// half period of the flashing ready lamp
`define BAC_FLASH_MS 250
`define BAC_FLASH_CYC (`BAC_FLASH_MS * `BAC_CYC_PER_MS)

// step of the undervoltage tolerance setting
`define BAC_UV_UNIT_MS 10
`define BAC_UV_UNIT_CYC (`BAC_UV_UNIT_MS * `BAC_CYC_PER_MS)

// reset values
`define BAC_RST_TMR 32'h0000_0000
`define BAC_RST_BIT 1'b0

`endif

// ==== verilog/bac_pkg.sv ====
package bac_pkg;

  // pins from the field, all asynchronous to clock
  typedef struct packed {
    logic remote_close_input;
    logic remote_open_input;
    logic local_close_button;
    logic local_open_button;
    logic direct_open_input;
    logic closing_lockout_input;
    logic undervoltage_release_input;
    logic supply_present;
    logic pos_open_sensor;
    logic pos_closed_sensor;
    logic energy_close_open_ok;
    logic energy_open_ok;
    logic store_full;
    logic close_coil_intact;
    logic open_coil_intact;
  } bac_pins_t;

  // configuration settings, static, same clock
  typedef struct packed {
    logic full_variant;
    logic uv_enable;
    logic [7:0] uv_tol_units;
  } bac_cfg_t;

  // outputs to coils, lamp, contacts and magnet
  typedef struct packed {
    logic close_coil;
    logic open_coil;
    logic ready_lamp;
    logic not_ready_contact;
    logic close_coil_fault_contact;
    logic open_coil_fault_contact;
    logic closed_position_contact;
    logic open_position_contact;
    logic carriage_blocking_magnet;
    logic charger_enable;
    logic recharge_fault;
    logic position_fault;
    logic uv_trip;
  } bac_outs_t;

  typedef enum logic [1:0] {
    BAC_ST_IDLE,
    BAC_ST_CLOSING,
    BAC_ST_OPENING
  } bac_state_t;

endpackage : bac_pkg

// ==== verilog/bac_sync.sv ====
`timescale 1ns/1ns
module bac_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : bac_sync

// ==== tb/bac_field_model.sv ====
`timescale 1ns/1ns
module bac_field_model #(
  parameter int MOVE_CYC = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic close_coil,
  input wire logic open_coil,
  input wire logic stuck,
  output logic pos_open_sensor,
  output logic pos_closed_sensor
);
  int unsigned travel_q;

  ////////////////////////////////////////////////////////////////////////////////
  // armature leaves its limit at once and needs MOVE_CYC + 1 coil cycles to latch;
  // a stuck armature never latches closed, so the close timeout can be reached
  // two limit sensors
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      travel_q <= 0;
      pos_open_sensor <= 1'b1;
      pos_closed_sensor <= 1'b0;
    end
    else if (close_coil || open_coil)
    begin
      travel_q <= travel_q + 1;
      pos_open_sensor <= 1'b0;
      pos_closed_sensor <= 1'b0;
      if (travel_q >= MOVE_CYC && open_coil)
        pos_open_sensor <= 1'b1;
      if (travel_q >= MOVE_CYC && close_coil && !stuck)
        pos_closed_sensor <= 1'b1;
    end
    else
      travel_q <= 0;
  end
endmodule : bac_field_model

// ==== tb/breaker_actuator_controller_test.sv ====
`timescale 1ns/1ns
module breaker_actuator_controller_test;
  import bac_pkg::*;
  localparam int TMO = 50;
  localparam int CC = 0;
  localparam int OC = 1;
  localparam int LAMP = 2;
  localparam int CPOS = 3;
  logic clock;
  logic reset_n;
  logic watchdog_ok;
  logic stuck;
  logic ce;
  logic jam_closed;
  logic pos_open;
  logic pos_closed;
  bac_pins_t pv;
  bac_pins_t pins;
  bac_pins_t good;
  bac_pins_t t;
  bac_cfg_t cfg;
  bac_outs_t outs;
  bac_state_t state;
  int num_errors;
  int n_compared;
  int n;

  bac_ctrl #(.CLOSE_TMO_CYC(TMO), .RECHARGE_CYC(200), .FLASH_CYC(8), .UV_UNIT_CYC(4)) uut (
    .clock(clock), .reset_n(reset_n), .ce(ce), .pins(pins), .cfg(cfg),
    .watchdog_ok(watchdog_ok), .outs(outs), .state(state));

  bac_field_model field (
    .clock(clock), .reset_n(reset_n), .close_coil(outs.close_coil),
    .open_coil(outs.open_coil), .stuck(stuck), .pos_open_sensor(pos_open),
    .pos_closed_sensor(pos_closed));

  always_comb
  begin
    pins = pv;
    pins.pos_open_sensor = pos_open;
    pins.pos_closed_sensor = pos_closed | jam_closed;
  end

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  function automatic logic pick(input int sel);
    case (sel)
      CC: return outs.close_coil;
      OC: return outs.open_coil;
      LAMP: return outs.ready_lamp;
      default: return outs.closed_position_contact;
    endcase
  endfunction : pick

  // bounded wait; a miss is counted and ends the run
  task automatic wait_for(input string name, input int sel, input logic val, input int lim);
    n = 0;
    while (pick(sel) !== val && n < lim)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    check(name, pick(sel), val);
    if (pick(sel) !== val)
      end_of_test();
  endtask : wait_for

  task automatic quiet(input int lim);
    repeat (lim)
    begin
      @(posedge clock);
      #1;
      check("close_coil idle", outs.close_coil, 1'b0);
    end
  endtask : quiet

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask : cyc

  task automatic close_op(input bit hold);
    @(posedge clock);
    pv.remote_close_input <= 1'b1;
    wait_for("close_coil on", CC, 1'b1, 10);
    wait_for("close_coil off", CC, 1'b0, 9);
    if (!hold)
    begin
      @(posedge clock);
      pv.remote_close_input <= 1'b0;
    end
  endtask : close_op

  task automatic open_op();
    @(posedge clock);
    pv.remote_open_input <= 1'b1;
    wait_for("open_coil on", OC, 1'b1, 10);
    wait_for("open_coil off", OC, 1'b0, 12);
    @(posedge clock);
    pv.remote_open_input <= 1'b0;
  endtask : open_op

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset_n = 1'b0;
    watchdog_ok = 1'b1;
    stuck = 1'b0;
    ce = 1'b1;
    jam_closed = 1'b0;
    num_errors = 0;
    n_compared = 0;
    good = '0;
    good.closing_lockout_input = 1'b1;
    good.supply_present = 1'b1;
    good.energy_close_open_ok = 1'b1;
    good.energy_open_ok = 1'b1;
    good.store_full = 1'b1;
    good.close_coil_intact = 1'b1;
    good.open_coil_intact = 1'b1;
    pv = good;
    cfg = '{full_variant: 1'b1, uv_enable: 1'b0, uv_tol_units: 8'h02};
    repeat (2) @(posedge clock);
    #1;
    check("outs in reset", outs, '0);
    @(posedge clock);
    reset_n <= 1'b1;
    // uv function off, no voltage on its input
    close_op(1'b0);
    wait_for("closed contact", CPOS, 1'b1, 4);
    check("open contact", outs.open_position_contact, 1'b0);
    open_op();
    @(posedge clock);
    cfg.uv_enable <= 1'b1;
    pv.undervoltage_release_input <= 1'b1;
    good.undervoltage_release_input = 1'b1;
    close_op(1'b0);
    @(posedge clock);
    pv.undervoltage_release_input <= 1'b0;
    cyc(9);
    #1;
    check("open_coil in tolerance", outs.open_coil, 1'b0);
    wait_for("uv open", OC, 1'b1, 15);
    check("uv trip flag", outs.uv_trip, 1'b1);
    wait_for("uv open done", OC, 1'b0, 12);
    @(posedge clock);
    pv <= good;
    cyc(8);
    // supply, lock-out, energy, open with close, uv voltage missing
    for (int i = 0; i < 5; i++)
    begin
      t = good;
      t.remote_close_input = 1'b1;
      case (i)
        0: t.supply_present = 1'b0;
        1: t.closing_lockout_input = 1'b0;
        2: t.energy_close_open_ok = 1'b0;
        3: t.remote_open_input = 1'b1;
        default: t.undervoltage_release_input = 1'b0;
      endcase
      @(posedge clock);
      pv <= t;
      quiet(12);
      check("ready_lamp", outs.ready_lamp, i != 0 && i != 2);
      check("magnet", outs.carriage_blocking_magnet, i != 0);
      if (i != 0)
        check("not ready", outs.not_ready_contact, i == 2);
      @(posedge clock);
      pv <= good;
      cyc(8);
    end
    // close held, then open: one cycle only
    close_op(1'b1);
    open_op();
    quiet(20);
    @(posedge clock);
    pv.remote_close_input <= 1'b0;
    cyc(4);
    close_op(1'b0);
    @(posedge clock);
    pv.direct_open_input <= 1'b1;
    wait_for("direct open", OC, 1'b1, 5);
    wait_for("direct open done", OC, 1'b0, 12);
    @(posedge clock);
    pv.direct_open_input <= 1'b0;
    pv.open_coil_intact <= 1'b0;
    cyc(5);
    #1;
    check("coil fault", outs.open_coil_fault_contact, 1'b1);
    check("lamp on fault", outs.ready_lamp, 1'b0);
    @(posedge clock);
    pv.open_coil_intact <= 1'b1;
    watchdog_ok <= 1'b0;
    cyc(5);
    #1;
    check("lamp no watchdog", outs.ready_lamp, 1'b0);
    @(posedge clock);
    watchdog_ok <= 1'b1;
    pv.store_full <= 1'b0;
    stuck <= 1'b1;
    cyc(5);
    // armature jams: the timed open must follow
    @(posedge clock);
    pv.remote_close_input <= 1'b1;
    wait_for("close_coil on", CC, 1'b1, 10);
    wait_for("timeout open", OC, 1'b1, TMO + 10);
    check("timeout length", n >= TMO - 3 && n <= TMO + 3, 1'b1);
    check("close_coil dropped", outs.close_coil, 1'b0);
    wait_for("timeout open done", OC, 1'b0, 15);
    @(posedge clock);
    pv.remote_close_input <= 1'b0;
    stuck <= 1'b0;
    // lamp flashes while recharging and closing stays possible
    wait_for("flash low", LAMP, 1'b0, 20);
    wait_for("flash high", LAMP, 1'b1, 20);
    close_op(1'b0);
    open_op();
    // store still not full: the watch must flag an overdue recharge
    cyc(180);
    #1;
    check("recharge fault early", outs.recharge_fault, 1'b0);
    check("charger on", outs.charger_enable, 1'b1);
    cyc(20);
    #1;
    check("recharge overdue", outs.recharge_fault, 1'b1);
    @(posedge clock);
    pv.store_full <= 1'b1;
    cyc(4);
    #1;
    check("recharge cleared", outs.recharge_fault, 1'b0);
    check("charger off", outs.charger_enable, 1'b0);
    // clock enable low freezes the whole block, synchroniser included
    @(posedge clock);
    ce <= 1'b0;
    pv.remote_close_input <= 1'b1;
    quiet(10);
    @(posedge clock);
    ce <= 1'b1;
    wait_for("close after freeze", CC, 1'b1, 10);
    wait_for("close_coil off", CC, 1'b0, 9);
    @(posedge clock);
    pv.remote_close_input <= 1'b0;
    open_op();
    // both sensors at once
    @(posedge clock);
    jam_closed <= 1'b1;
    cyc(4);
    #1;
    check("position fault", outs.position_fault, 1'b1);
    check("lamp undefined position", outs.ready_lamp, 1'b0);
    @(posedge clock);
    jam_closed <= 1'b0;
    cyc(4);
    // standard variant ignores coil breaks and gives no extra contacts
    cfg.full_variant <= 1'b0;
    pv.open_coil_intact <= 1'b0;
    cyc(4);
    #1;
    check("fault contact basic", outs.open_coil_fault_contact, 1'b0);
    check("open contact basic", outs.open_position_contact, 1'b0);
    check("lamp basic", outs.ready_lamp, 1'b1);
    end_of_test();
  end
endmodule : breaker_actuator_controller_test
